// ==== rtl/sitm_pkg.sv ====
// Package: telegram layout constants for the safe I/O telegram map
package sitm_pkg;
  // ----------------------------------------
  // Telegram sizes
  // ----------------------------------------
  localparam int OUT_BYTES = 6;
  localparam int IN_BYTES = 7;
  // ----------------------------------------
  // Output telegram byte positions
  // ----------------------------------------
  localparam int OB_SEL1 = 0;
  localparam int OB_SEL2 = 2;
  localparam int OB_START_A = 4;
  localparam int OB_START_B = 5;
  localparam int SEL_W = 5;
  localparam int BIT_WARN = 0;
  localparam int BIT_GUARD = 1;
  // ----------------------------------------
  // Input telegram byte positions
  // ----------------------------------------
  localparam int IB_ZONE_A = 0;
  localparam int IB_ZONE_B = 1;
  localparam int IB_STATUS = 2;
  localparam int IB_CRC = 3;
  // ----------------------------------------
  // Function modes and reset values
  // ----------------------------------------
  typedef enum logic {SITM_FOUR_FIELD, SITM_MULTI_CFG} sitm_mode_t;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] SEL_RST = 5'h00;
  // Zones read as occupied after reset: the safe state
  localparam logic [1:0] ZONE_RST = 2'h0;
  // ----------------------------------------
  // Interrupt register layout and register addresses of the controller end
  // ----------------------------------------
  localparam int IRQ_W = 3;
  localparam int EV_A_OCC = 0;
  localparam int EV_B_OCC = 1;
  localparam int EV_RX = 2;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_START = 4'h1;
  localparam logic [3:0] ADDR_ZONES = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_CRC = 4'h4;
  localparam logic [3:0] ADDR_IRQ = 4'h5;
  localparam logic [3:0] ADDR_MASK = 4'h6;
  localparam logic [3:0] ADDR_MODE = 4'h7;
endpackage

// ==== rtl/sitm_if.sv ====
// Interface: cyclic telegram exchange between controller and device
`timescale 1ns/1ps
`default_nettype none
interface sitm_if;
  logic [7:0] out_tel [sitm_pkg::OUT_BYTES];
  logic out_valid;
  logic [7:0] in_tel [sitm_pkg::IN_BYTES];
  logic in_valid;
  modport ctrl (output out_tel, output out_valid, input in_tel, input in_valid);
  modport dev (input out_tel, input out_valid, output in_tel, output in_valid);
endinterface
`default_nettype wire

// ==== rtl/sitm_device.sv ====
// Device end: decodes output telegrams, packs input telegrams
//
// Operation
// R1 - Four-field: byte0 bits0-4 select group one
// R2 - Four-field: byte2 bits0-4 select group two
// R3 - Byte4 bits0/1: function A restart requests
// R4 - Byte5 bits0/1: function B restart requests
// R5 - Multi-config: byte0 bits0-4 select bank
// R6 - Multi-config: byte2 bits0-4 select fields 6-10
// R7 - Input byte0: A warn/guard free flags
// R8 - Input byte1: B warn/guard free flags
// R9 - Status byte2, CRC bytes3-6 MSB first
// R10 - Decode output bytes per configured mode
// R11 - Active start bit releases manual restart
// R12 - Reserved bits sent zero, ignored
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-flop synchroniser for asynchronous scanner pins
// ----------------------------------------
// Only the second stage is read outside this module, so a
// metastable first stage never reaches the telegram.
module sitm_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Pin in, synchronised copy out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  // Reset to zero: zones read as occupied, the safe state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule // sitm_sync2

module sitm_device (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Telegram link
  sitm_if.dev link,
  // Configuration and scanner state
  input wire logic mode_in,
  input wire logic [1:0] zone_a_in,
  input wire logic [1:0] zone_b_in,
  input wire logic [7:0] status_in,
  input wire logic [31:0] crc_in,
  // Decoded orders
  output logic [4:0] pair_sel_out,
  output logic [4:0] bank_sel_out,
  output logic [4:0] field_sel_out,
  output logic [1:0] release_a_out,
  output logic [1:0] release_b_out
);
  // ----------------------------------------
  // Behaviour in brief
  // ----------------------------------------
  // Orders are taken only on a cycle with a valid telegram, so a
  // controller that stops sending leaves the last orders standing.
  // The mode input decides whether byte0 updates the pair or the bank
  // selection; the other keeps its value for a later switch, and byte2 updates the field selection in both modes.
  // Restart releases are levels and stand until the next telegram;
  // a controller must send them inactive again to end the release.
  // Zone pins come from the scanner's own timing and pass two flops
  // before use; both stages reset to zero so zones read occupied.
  // Reserved bits of received bytes are never looked at, and every
  // reserved bit sent back is forced to zero.

  // ----------------------------------------
  // Pin synchronisers for scanner zone states
  // ----------------------------------------
  logic [1:0] zone_a_sync;
  logic [1:0] zone_b_sync;
  // Function A zone pins
  sitm_sync2 #(
    .W(2)
  ) u_sitm_sync2_a (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .pin_in(zone_a_in),
    .sync_out(zone_a_sync)
  );
  // Function B zone pins
  sitm_sync2 #(
    .W(2)
  ) u_sitm_sync2_b (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .pin_in(zone_b_in),
    .sync_out(zone_b_sync)
  );
  // Named zone flags, 1 means free
  wire warn_zone_a_free = zone_a_sync[sitm_pkg::BIT_WARN]; // R7
  wire guard_zone_free = zone_a_sync[sitm_pkg::BIT_GUARD]; // R7
  wire warn_zone_b_free = zone_b_sync[sitm_pkg::BIT_WARN]; // R8
  wire guard_zone_b_free = zone_b_sync[sitm_pkg::BIT_GUARD]; // R8

  // ----------------------------------------
  // Output telegram decode
  // ----------------------------------------
  wire four_field = (mode_in == sitm_pkg::SITM_FOUR_FIELD);
  wire [4:0] sel1 = link.out_tel[sitm_pkg::OB_SEL1][4:0]; // R12
  wire [4:0] sel2 = link.out_tel[sitm_pkg::OB_SEL2][4:0]; // R12
  wire [1:0] st_a = link.out_tel[sitm_pkg::OB_START_A][1:0];
  wire [1:0] st_b = link.out_tel[sitm_pkg::OB_START_B][1:0];
  logic [4:0] pair_sel_reg;
  logic [4:0] bank_sel_reg;
  logic [4:0] field_sel_reg;
  logic [1:0] release_a_reg;
  logic [1:0] release_b_reg;
  // Next values: each mode keeps the selection it does not use
  wire telegram_take = link.out_valid;
  wire [4:0] pair_sel_next = (telegram_take && four_field) ? sel1 : pair_sel_reg; // R1 R10
  wire [4:0] bank_sel_next = (telegram_take && !four_field) ? sel1 : bank_sel_reg; // R5 R10
  wire [4:0] field_sel_next = telegram_take ? sel2 : field_sel_reg; // R2 R6
  // Restart releases follow the latest telegram as levels
  wire [1:0] release_a_next = telegram_take ? st_a : release_a_reg; // R3 R11
  wire [1:0] release_b_next = telegram_take ? st_b : release_b_reg; // R4 R11

  // Selections stand until the next valid telegram
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pair_sel_reg <= sitm_pkg::SEL_RST;
      bank_sel_reg <= sitm_pkg::SEL_RST;
      field_sel_reg <= sitm_pkg::SEL_RST;
    end else begin
      pair_sel_reg <= pair_sel_next;
      bank_sel_reg <= bank_sel_next;
      field_sel_reg <= field_sel_next;
    end
  end

  // Releases reset inactive so no restart follows a reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      release_a_reg <= 2'h0;
      release_b_reg <= 2'h0;
    end else begin
      release_a_reg <= release_a_next;
      release_b_reg <= release_b_next;
    end
  end
  // Orders leave straight from their flops
  assign pair_sel_out = pair_sel_reg;
  assign bank_sel_out = bank_sel_reg;
  assign field_sel_out = field_sel_reg;
  assign release_a_out = release_a_reg;
  assign release_b_out = release_b_reg;

  // ----------------------------------------
  // Input telegram pack
  // ----------------------------------------
  // CRC bytes, top byte travels first
  wire [7:0] crc_byte_top = crc_in[31:24]; // R9
  wire [7:0] crc_byte_upper_mid = crc_in[23:16]; // R9
  wire [7:0] crc_byte_lower_mid = crc_in[15:8]; // R9
  wire [7:0] crc_byte_bottom = crc_in[7:0]; // R9
  // Zone bytes with reserved bits held at zero
  wire [7:0] zone_a_byte = {6'h00, guard_zone_free, warn_zone_a_free}; // R7 R12
  wire [7:0] zone_b_byte = {6'h00, guard_zone_b_free, warn_zone_b_free}; // R8 R12
  logic [7:0] in_tel_reg [sitm_pkg::IN_BYTES];
  logic in_valid_reg;

  // Input telegram refreshed every cycle once out of reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < sitm_pkg::IN_BYTES; i++) begin
        in_tel_reg[i] <= sitm_pkg::BYTE_RST;
      end
    end else begin
      in_tel_reg[sitm_pkg::IB_ZONE_A] <= zone_a_byte; // R7
      in_tel_reg[sitm_pkg::IB_ZONE_B] <= zone_b_byte; // R8
      in_tel_reg[sitm_pkg::IB_STATUS] <= status_in; // R9
      in_tel_reg[sitm_pkg::IB_CRC] <= crc_byte_top; // R9
      in_tel_reg[sitm_pkg::IB_CRC + 1] <= crc_byte_upper_mid; // R9
      in_tel_reg[sitm_pkg::IB_CRC + 2] <= crc_byte_lower_mid; // R9
      in_tel_reg[sitm_pkg::IB_CRC + 3] <= crc_byte_bottom; // R9
    end
  end

  // Valid rises at the first edge after reset and then stays high,
  // so the controller never reads the reset bytes as live data
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_valid_reg <= 1'b0;
    end else begin
      in_valid_reg <= 1'b1;
    end
  end

  // Input telegram onto the link
  always_comb begin
    for (int i = 0; i < sitm_pkg::IN_BYTES; i++) begin
      link.in_tel[i] = in_tel_reg[i];
    end
  end
  assign link.in_valid = in_valid_reg;
endmodule // sitm_device
`default_nettype wire

// ==== rtl/sitm_ctrl.sv ====
// Controller end: builds output telegrams, reads input telegrams
`timescale 1ns/1ps
`default_nettype none
module sitm_ctrl (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Telegram link
  sitm_if.ctrl link,
  // Software port
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [9:0] ctrl_reg;
  logic [3:0] start_reg;
  logic mode_reg;
  logic [sitm_pkg::IRQ_W-1:0] irq_reg;
  logic [sitm_pkg::IRQ_W-1:0] mask_reg;
  logic [31:0] rdata_reg;
  logic irq_o_reg;
  logic send_reg;
  logic [3:0] zones_reg;
  logic [7:0] status_reg;
  logic [31:0] crc_reg;
  wire wr_ctrl = wr_in && (addr_in == sitm_pkg::ADDR_CTRL);
  wire wr_start = wr_in && (addr_in == sitm_pkg::ADDR_START);
  wire wr_mask = wr_in && (addr_in == sitm_pkg::ADDR_MASK);
  wire wr_mode = wr_in && (addr_in == sitm_pkg::ADDR_MODE);
  wire rd_irq = rd_in && (addr_in == sitm_pkg::ADDR_IRQ);
  // Zone falls to occupied, or telegram arrived
  wire [3:0] new_zones = {link.in_tel[1][1:0], link.in_tel[0][1:0]}; // R12
  wire ev_a = link.in_valid && (new_zones[1:0] != 2'h3) && (zones_reg[1:0] == 2'h3);
  wire ev_b = link.in_valid && (new_zones[3:2] != 2'h3) && (zones_reg[3:2] == 2'h3);
  wire [2:0] events = {link.in_valid, ev_b, ev_a};
  wire [31:0] rd_mux =
    (addr_in == sitm_pkg::ADDR_CTRL) ? {22'h0, ctrl_reg} :
    (addr_in == sitm_pkg::ADDR_START) ? {28'h0, start_reg} :
    (addr_in == sitm_pkg::ADDR_ZONES) ? {28'h0, zones_reg} :
    (addr_in == sitm_pkg::ADDR_STATUS) ? {24'h0, status_reg} :
    (addr_in == sitm_pkg::ADDR_CRC) ? crc_reg :
    (addr_in == sitm_pkg::ADDR_IRQ) ? {29'h0, irq_reg} :
    (addr_in == sitm_pkg::ADDR_MASK) ? {29'h0, mask_reg} :
    (addr_in == sitm_pkg::ADDR_MODE) ? {31'h0, mode_reg} : 32'h0;
  // Register writes and reads
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= 10'h000;
      start_reg <= 4'h0;
      mode_reg <= 1'b0;
      mask_reg <= 3'h0;
      rdata_reg <= 32'h0;
      send_reg <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wdata_in[9:0];
      if (wr_start) start_reg <= wdata_in[3:0];
      if (wr_mask) mask_reg <= wdata_in[2:0];
      if (wr_mode) mode_reg <= wdata_in[0];
      send_reg <= wr_ctrl || wr_start || wr_mode;
      rdata_reg <= rd_in ? rd_mux : 32'h0;
    end
  end
  // Sticky events, set wins over read clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_reg <= 3'h0;
      irq_o_reg <= 1'b0;
    end else begin
      irq_reg <= (rd_irq ? 3'h0 : irq_reg) | events;
      irq_o_reg <= |(((rd_irq ? 3'h0 : irq_reg) | events) & mask_reg);
    end
  end
  // Capture input telegram
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      zones_reg <= 4'h0;
      status_reg <= 8'h00;
      crc_reg <= 32'h0;
    end else if (link.in_valid) begin
      zones_reg <= new_zones;
      status_reg <= link.in_tel[2];
      crc_reg <= {link.in_tel[3], link.in_tel[4], link.in_tel[5], link.in_tel[6]};
    end
  end
  assign rdata_out = rdata_reg;
  assign irq_out = irq_o_reg;

  // ----------------------------------------
  // Output telegram build, reserved bits zero
  // ----------------------------------------
  always_comb begin
    link.out_tel[0] = {3'h0, ctrl_reg[4:0]}; // R1 R5 R12
    link.out_tel[1] = 8'h00; // R12
    link.out_tel[2] = {3'h0, ctrl_reg[9:5]}; // R2 R6 R12
    link.out_tel[3] = 8'h00; // R12
    link.out_tel[4] = {6'h00, start_reg[1:0]}; // R3 R12
    link.out_tel[5] = {6'h00, start_reg[3:2]}; // R4 R12
  end
  assign link.out_valid = send_reg;
endmodule // sitm_ctrl
`default_nettype wire

// ==== bench/sitm_props.sv ====
// Checker: wire properties of the telegram link between both ends
`timescale 1ns/1ps
`default_nettype none
module sitm_props (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Telegram link
  input wire logic [7:0] out_tel [sitm_pkg::OUT_BYTES],
  input wire logic out_valid,
  input wire logic [7:0] in_tel [sitm_pkg::IN_BYTES],
  input wire logic in_valid
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_live;
    in_valid ##1 in_valid;
  endsequence
  property p_sel1_hold; $changed(out_tel[0]) |-> out_valid; endproperty
  property p_sel2_hold; $changed(out_tel[2]) |-> out_valid; endproperty
  property p_sta_hold; $changed(out_tel[4]) |-> out_valid; endproperty
  property p_stb_hold; $changed(out_tel[5]) |-> out_valid; endproperty
  property p_rsv_bytes; out_tel[1] == 8'h00 && out_tel[3] == 8'h00; endproperty
  property p_rsv_bits;
    out_tel[0][7:5] == 3'h0 && out_tel[2][7:5] == 3'h0 && out_tel[4][7:2] == 6'h00
      && out_tel[5][7:2] == 6'h00;
  endproperty
  property p_zone_rsv; in_tel[0][7:2] == 6'h00 && in_tel[1][7:2] == 6'h00; endproperty
  property p_in_live; in_valid |-> s_live; endproperty
  a_sel1_hold: assert property (p_sel1_hold) else $error("byte0 moved without valid");
  a_sel2_hold: assert property (p_sel2_hold) else $error("byte2 moved without valid");
  a_sta_hold: assert property (p_sta_hold) else $error("byte4 moved without valid");
  a_stb_hold: assert property (p_stb_hold) else $error("byte5 moved without valid");
  a_rsv_bytes: assert property (p_rsv_bytes) else $error("spare byte not zero");
  a_rsv_bits: assert property (p_rsv_bits) else $error("spare bits not zero");
  a_zone_rsv: assert property (p_zone_rsv) else $error("spare zone bits set");
  a_in_live: assert property (p_in_live) else $error("input telegram dropped");
endmodule // sitm_props
`default_nettype wire

// ==== bench/safe_io_telegram_map_tb.sv ====
// Testbench: controller and device joined over the telegram link
`timescale 1ns/1ps
`default_nettype none
module safe_io_telegram_map_tb;
  logic core_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, mode_in = 1'b0;
  logic dev_chk = 1'b0, rd_d = 1'b0, dv1 = 1'b0, dv2 = 1'b0, irq_out;
  logic [3:0] addr_in = 4'h0;
  logic [1:0] zone_a_in = 2'h0, zone_b_in = 2'h0, release_a_out, release_b_out;
  logic [7:0] status_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, crc_in = 32'h0, w1, w2, dv, rdata_out;
  logic [4:0] pe = 5'h00, be = 5'h00, pair_sel_out, bank_sel_out, field_sel_out;
  logic [31:0] q [$];
  int error_cnt = 0, cmp_count = 0, seed = 3;
  wire logic [31:0] dev_vec;
  // Device outputs and the controller interrupt packed for comparison
  assign dev_vec = {12'h0, irq_out, release_b_out, release_a_out, field_sel_out, bank_sel_out,
    pair_sel_out};
  // Clock
  always #10 core_clk_in = ~core_clk_in;
  sitm_if link_if ();
  sitm_ctrl u_sitm_ctrl (.core_clk_in, .rst_in, .link(link_if.ctrl), .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .irq_out);
  sitm_device u_sitm_device (.core_clk_in, .rst_in, .link(link_if.dev), .mode_in, .zone_a_in,
    .zone_b_in, .status_in, .crc_in, .pair_sel_out, .bank_sel_out, .field_sel_out,
    .release_a_out, .release_b_out);
  sitm_props u_sitm_props (.core_clk_in, .rst_in, .out_tel(link_if.out_tel),
    .out_valid(link_if.out_valid), .in_tel(link_if.in_tel), .in_valid(link_if.in_valid));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    wr_in <= w;
    rd_in <= !w;
    addr_in <= a;
    wdata_in <= d;
    dev_chk <= c;
    @(posedge core_clk_in);
  endtask
  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    dev_chk <= 1'b0;
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    acc(1'b0, a, 32'h0, 1'b0);
  endtask
  // Result watcher: each appearing result against the oldest note
  always @(posedge core_clk_in) begin
    rd_d <= rd_in;
    dv1 <= dev_chk;
    dv2 <= dv1;
    if (rd_d || dv2) check(rd_d ? rdata_out : dev_vec, q.size() > 0 ? q.pop_front() : 'x);
  end
  // Hang guard
  initial begin
    repeat (4000) @(posedge core_clk_in);
    error_cnt++;
    $display("BAD %0t: run did not finish", $time);
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(sitm_pkg::ADDR_CTRL, 32'h0);
    acc(1'b1, 4'h9, 32'hffffffff, 1'b0);
    rd(4'h9, 32'h0);
    idle(2);
    $display("done: reset and unmapped");
    for (int i = 0; i < 8; i++) begin
      mode_in <= i[0];
      w1 = $random(seed);
      w2 = $random(seed);
      if (i[0]) be = w1[4:0];
      else pe = w1[4:0];
      dv = {12'h0, 1'b0, w2[3:0], w1[9:5], be, pe};
      q.push_back(dv);
      acc(1'b1, sitm_pkg::ADDR_CTRL, w1, 1'b0);
      acc(1'b1, sitm_pkg::ADDR_START, w2, 1'b1);
      idle(4);
    end
    acc(1'b1, sitm_pkg::ADDR_MODE, 32'h1, 1'b0);
    rd(sitm_pkg::ADDR_MODE, 32'h1);
    rd(sitm_pkg::ADDR_START, {28'h0, w2[3:0]});
    idle(1);
    $display("done: telegrams");
    zone_a_in <= w1[1:0];
    zone_b_in <= w2[1:0];
    status_in <= w1[17:10];
    crc_in <= w2;
    idle(8);
    rd(sitm_pkg::ADDR_ZONES, {28'h0, w2[1:0], w1[1:0]});
    rd(sitm_pkg::ADDR_STATUS, {24'h0, w1[17:10]});
    rd(sitm_pkg::ADDR_CRC, w2);
    idle(1);
    $display("done: input telegram");
    q.push_back(dv | 32'h80000);
    acc(1'b1, sitm_pkg::ADDR_MASK, 32'h7, 1'b1);
    idle(4);
    rd(sitm_pkg::ADDR_MASK, 32'h7);
    zone_a_in <= 2'h3;
    zone_b_in <= 2'h3;
    idle(8);
    zone_a_in <= 2'h0;
    zone_b_in <= 2'h0;
    idle(8);
    rd(sitm_pkg::ADDR_IRQ, 32'h7);
    rd(sitm_pkg::ADDR_IRQ, 32'h4);
    q.push_back(dv);
    acc(1'b1, sitm_pkg::ADDR_MASK, 32'h0, 1'b1);
    idle(4);
    $display("done: interrupts");
    complete_run();
  end
endmodule // safe_io_telegram_map_tb
`default_nettype wire
